// ---- logic/serial_baud_pkg.sv ----
// constants for the serial channel baud generator and fifo configuration block
// assumes an apb slave with 32-bit data, one aligned word per register
package serial_baud_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_BAUD_DIVIDER = 12'h000;
  localparam logic [11:0] OFS_BAUD_FRACTION = 12'h004;
  localparam logic [11:0] OFS_FIFO_CONFIG = 12'h008;
  localparam logic [11:0] OFS_CHANNEL_ENABLE = 12'h00C;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h010;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h014;
  localparam logic [11:0] OFS_GEN_STATUS = 12'h018;
  // baud_divider_control fields
  localparam int DIV_N_LSB = 0;
  localparam int DIV_TAP_LSB = 4;
  localparam int DIV_FRAC_EN_BIT = 6;
  localparam int DIV_SPARE_BIT = 7;
  // fifo_configuration fields
  localparam int FCF_FIFO_EN_BIT = 0;
  localparam int FCF_AUTO_DIS_BIT = 1;
  localparam int FCF_RX_IRQ_EN_BIT = 2;
  localparam int FCF_TX_IRQ_EN_BIT = 3;
  localparam int FCF_USAGE_BIT = 4;
  // channel enable fields
  localparam int ENA_TX_BIT = 0;
  localparam int ENA_RX_BIT = 1;
  // sticky status bits
  localparam int IRQ_TX_FIFO = 0;
  localparam int IRQ_RX_FIFO = 1;
  localparam int IRQ_AUTO_OFF = 2;
  localparam int IRQ_BAD_K = 3;
  localparam int IRQ_W = 4;
  // reset values
  localparam logic [7:0] RST_BAUD_DIVIDER = 8'h00;
  localparam logic [3:0] RST_BAUD_FRACTION = 4'h0;
  localparam logic [7:0] RST_FIFO_CONFIG = 8'h00;
  localparam logic [IRQ_W-1:0] RST_IRQ = 4'h0;
  // divisor encoding: code zero means sixteen
  localparam logic [3:0] N_CODE_SIXTEEN = 4'h0;
  localparam logic [4:0] N_SIXTEEN = 5'h10;
  localparam logic [3:0] K_PROHIBITED = 4'h0;
  localparam logic [4:0] FRAC_BASE = 5'h10;
  // prescaler tap codes
  localparam logic [1:0] TAP_A = 2'h0;
  localparam logic [1:0] TAP_B = 2'h1;
  localparam logic [1:0] TAP_C = 2'h2;
  localparam logic [1:0] TAP_D = 2'h3;
  // duplex settings
  localparam logic [1:0] DPX_OFF = 2'h0;
  localparam logic [1:0] DPX_HALF_RX = 2'h1;
  localparam logic [1:0] DPX_HALF_TX = 2'h2;
  localparam logic [1:0] DPX_FULL = 2'h3;
  // fifo depths in bytes
  localparam logic [2:0] DEPTH_HALF = 3'h4;
  localparam logic [2:0] DEPTH_FULL = 3'h2;
  localparam logic [2:0] DEPTH_NONE = 3'h0;
endpackage : serial_baud_pkg

// ---- logic/baud_divider.sv ----
// baud divider: counts selected prescaler ticks, optional fractional stretch
// assumes tick_in is a one-cycle pulse on sys_clk and settings are held steady
module baud_divider (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tick_in,
  input wire logic [4:0] divisor,
  input wire logic [3:0] frac_k,
  input wire logic frac_on,
  output logic baud_tick
);
  logic [4:0] cnt;
  logic stretch;
  logic [3:0] acc;
  logic [5:0] period;
  logic [4:0] frac_sum;
  logic [4:0] gap;
  logic [4:0] last_divisor;
  logic last_frac_on;
  logic cfg_change;
  logic cfg_moved;

  assign period = {1'b0, divisor} + {5'h00, stretch};
  assign frac_sum = {1'b0, acc} + (serial_baud_pkg::FRAC_BASE - {1'b0, frac_k});

  // tick counter; the carry spreads the stretches evenly instead of in a burst
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 5'h00;
      stretch <= 1'b0;
      acc <= 4'h0;
      baud_tick <= 1'b0;
    end else if (tick_in && ({1'b0, cnt} + 6'h01 >= period)) begin
      cnt <= 5'h00;
      baud_tick <= 1'b1;
      if (frac_on) begin
        acc <= frac_sum[3:0];
        stretch <= frac_sum[4];
      end else begin
        acc <= 4'h0;
        stretch <= 1'b0;
      end
    end else begin
      cnt <= tick_in ? cnt + 5'h01 : cnt;
      baud_tick <= 1'b0;
    end
  end

  // settings one cycle ago; a period that spans a change may be odd and is not checked
  assign cfg_change = (divisor != last_divisor) || (frac_on != last_frac_on);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_divisor <= 5'h00;
      last_frac_on <= 1'b0;
    end else begin
      last_divisor <= divisor;
      last_frac_on <= frac_on;
    end
  end

  // ticks seen in the current period, for checking only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap <= 5'h00;
      cfg_moved <= 1'b1;
    end else if (baud_tick) begin
      gap <= {4'h0, tick_in};
      cfg_moved <= cfg_change;
    end else begin
      gap <= gap + {4'h0, tick_in};
      cfg_moved <= cfg_moved || cfg_change;
    end
  end

  AST_PERIOD_LEN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    baud_tick && !cfg_moved && $stable(divisor) && $stable(frac_on) && !$past(baud_tick)
    |-> (gap == divisor) || (frac_on && ({1'b0, gap} == {1'b0, divisor} + 6'h01)))
    else $error("baud period is not n or n plus one ticks");
  AST_NO_STRETCH_PLAIN: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(!frac_on) && baud_tick |-> !stretch)
    else $error("period stretched while fractional divide is off");
  COV_STRETCHED: cover property (@(posedge sys_clk) disable iff (!rst_n)
    baud_tick && stretch);
endmodule : baud_divider

// ---- logic/serial_baud_fifo_config.sv ----
// baud rate generator and fifo configuration of a serial channel, apb slave
// assumes prescaler ticks and engine status come from logic on sys_clk
// Operation
// - divide by n, or by n plus (16-k)/16 when fractional on in uart mode
// - two-bit tap code picks tick a, b, c or d as divider input
// - divisor code 1 to 15 means itself, code zero means sixteen
// - k is 1 to 15; a write of code zero is refused and not stored, though reset loads zero
// - usage select picks full fifo depth or receive interrupt fill level
// - transmit fifo interrupts pass only while their enable is set
// - receive fifo interrupts pass only while their enable is set
// - a control bit turns automatic disabling of transmit and receive on
// - half duplex receive: clear receive enable once fill target is reached
// - half duplex transmit: clear transmit enable once all transmit stages empty
// - full duplex: either condition clears both enables
// - fifo enabled: depth 4 rx, 4 tx, or 2 each way per duplex setting
//
// The implementer's own choices: the address map and the APB register port.
module serial_baud_fifo_config (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic prescaler_tick_a,
  input wire logic prescaler_tick_b,
  input wire logic prescaler_tick_c,
  input wire logic prescaler_tick_d,
  input wire logic uart_mode,
  input wire logic [1:0] duplex_mode,
  input wire logic [2:0] rx_irq_fill_level,
  input wire logic [2:0] rx_valid_bytes,
  input wire logic tx_all_empty,
  input wire logic tx_fifo_event,
  input wire logic rx_fifo_event,
  output logic baud_tick,
  output logic tx_enable,
  output logic rx_enable,
  output logic [2:0] rx_fifo_depth,
  output logic [2:0] tx_fifo_depth,
  output logic [2:0] rx_fifo_usable,
  output logic tx_fifo_irq,
  output logic rx_fifo_irq,
  output logic irq
);
  logic [7:0] baud_divider_control;
  logic [3:0] baud_fraction_control;
  logic [7:0] fifo_configuration;
  logic [serial_baud_pkg::IRQ_W-1:0] irq_status;
  logic [serial_baud_pkg::IRQ_W-1:0] irq_mask;
  logic access;
  logic wr_now;
  logic [3:0] n_code;
  logic [1:0] tap_code;
  logic frac_req;
  logic fifo_en;
  logic auto_dis;
  logic [4:0] n_value;
  logic sel_tick;
  logic frac_on;
  logic tx_empty_d;
  logic rx_done;
  logic tx_done;
  logic clr_rx;
  logic clr_tx;
  logic bad_k_write;
  logic [2:0] next_rx_depth;
  logic [2:0] next_tx_depth;
  logic [serial_baud_pkg::IRQ_W-1:0] irq_set;
  logic [31:0] next_prdata;
  logic addr_ok;

  // bus phases: pready rises one cycle into the access phase
  assign access = psel && penable;
  assign wr_now = access && pready && pwrite;

  // field views
  assign n_code = baud_divider_control[serial_baud_pkg::DIV_N_LSB +: 4];
  assign tap_code = baud_divider_control[serial_baud_pkg::DIV_TAP_LSB +: 2];
  assign frac_req = baud_divider_control[serial_baud_pkg::DIV_FRAC_EN_BIT];
  assign fifo_en = fifo_configuration[serial_baud_pkg::FCF_FIFO_EN_BIT];
  assign auto_dis = fifo_configuration[serial_baud_pkg::FCF_AUTO_DIS_BIT];

  assign n_value = (n_code == serial_baud_pkg::N_CODE_SIXTEEN) ?
    serial_baud_pkg::N_SIXTEEN : {1'b0, n_code};

  assign frac_on = frac_req && uart_mode;

  always_comb begin
    case (tap_code)
      serial_baud_pkg::TAP_A: sel_tick = prescaler_tick_a;
      serial_baud_pkg::TAP_B: sel_tick = prescaler_tick_b;
      serial_baud_pkg::TAP_C: sel_tick = prescaler_tick_c;
      default: sel_tick = prescaler_tick_d;
    endcase
  end

  baud_divider u_divider (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tick_in(sel_tick),
    .divisor(n_value),
    .frac_k(baud_fraction_control),
    .frac_on(frac_on),
    .baud_tick(baud_tick)
  );

  always_comb begin
    next_rx_depth = serial_baud_pkg::DEPTH_NONE;
    next_tx_depth = serial_baud_pkg::DEPTH_NONE;
    if (fifo_en) begin
      case (duplex_mode)
        serial_baud_pkg::DPX_HALF_RX: next_rx_depth = serial_baud_pkg::DEPTH_HALF;
        serial_baud_pkg::DPX_HALF_TX: next_tx_depth = serial_baud_pkg::DEPTH_HALF;
        serial_baud_pkg::DPX_FULL: begin
          next_rx_depth = serial_baud_pkg::DEPTH_FULL;
          next_tx_depth = serial_baud_pkg::DEPTH_FULL;
        end
        default: begin
          next_rx_depth = serial_baud_pkg::DEPTH_NONE;
          next_tx_depth = serial_baud_pkg::DEPTH_NONE;
        end
      endcase
    end
  end

  // depth and usage outputs, registered
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_fifo_depth <= serial_baud_pkg::DEPTH_NONE;
      tx_fifo_depth <= serial_baud_pkg::DEPTH_NONE;
      rx_fifo_usable <= serial_baud_pkg::DEPTH_NONE;
    end else begin
      rx_fifo_depth <= next_rx_depth;
      tx_fifo_depth <= next_tx_depth;
      rx_fifo_usable <= fifo_configuration[serial_baud_pkg::FCF_USAGE_BIT] ?
        rx_irq_fill_level : next_rx_depth;
    end
  end

  // completion conditions; transmit counts the moment all stages drain
  assign rx_done = rx_enable && (rx_fifo_usable != serial_baud_pkg::DEPTH_NONE) &&
    (rx_valid_bytes >= rx_fifo_usable);
  assign tx_done = tx_enable && tx_all_empty && !tx_empty_d;

  always_comb begin
    clr_rx = 1'b0;
    clr_tx = 1'b0;
    if (auto_dis) begin
      case (duplex_mode)
        serial_baud_pkg::DPX_HALF_RX: clr_rx = rx_done;
        serial_baud_pkg::DPX_HALF_TX: clr_tx = tx_done;
        serial_baud_pkg::DPX_FULL: begin
          clr_rx = rx_done || tx_done;
          clr_tx = rx_done || tx_done;
        end
        default: begin
          clr_rx = 1'b0;
          clr_tx = 1'b0;
        end
      endcase
    end
  end

  // drain edge detector
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_empty_d <= 1'b1;
    end else begin
      tx_empty_d <= tx_all_empty;
    end
  end

  // channel enables: the automatic clear beats a software set in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_enable <= 1'b0;
      rx_enable <= 1'b0;
    end else begin
      if (clr_tx) begin
        tx_enable <= 1'b0;
      end else if (wr_now && paddr == serial_baud_pkg::OFS_CHANNEL_ENABLE) begin
        tx_enable <= pwdata[serial_baud_pkg::ENA_TX_BIT];
      end
      if (clr_rx) begin
        rx_enable <= 1'b0;
      end else if (wr_now && paddr == serial_baud_pkg::OFS_CHANNEL_ENABLE) begin
        rx_enable <= pwdata[serial_baud_pkg::ENA_RX_BIT];
      end
    end
  end

  // configuration registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      baud_divider_control <= serial_baud_pkg::RST_BAUD_DIVIDER;
      fifo_configuration <= serial_baud_pkg::RST_FIFO_CONFIG;
      irq_mask <= serial_baud_pkg::RST_IRQ;
    end else if (wr_now) begin
      case (paddr)
        serial_baud_pkg::OFS_BAUD_DIVIDER: baud_divider_control <= pwdata[7:0];
        // upper three bits must stay zero, so they are not stored
        serial_baud_pkg::OFS_FIFO_CONFIG: fifo_configuration <= {3'h0, pwdata[4:0]};
        serial_baud_pkg::OFS_IRQ_MASK: irq_mask <= pwdata[serial_baud_pkg::IRQ_W-1:0];
        default: irq_mask <= irq_mask;
      endcase
    end
  end

  assign bad_k_write = wr_now && (paddr == serial_baud_pkg::OFS_BAUD_FRACTION) &&
    (pwdata[3:0] == serial_baud_pkg::K_PROHIBITED);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      baud_fraction_control <= serial_baud_pkg::RST_BAUD_FRACTION;
    end else if (wr_now && paddr == serial_baud_pkg::OFS_BAUD_FRACTION && !bad_k_write) begin
      baud_fraction_control <= pwdata[3:0];
    end
  end

  // interrupt events; the two fifo events are gated by their enables, bad k and auto off are not
  assign irq_set = {bad_k_write, clr_rx || clr_tx,
    rx_fifo_event && fifo_configuration[serial_baud_pkg::FCF_RX_IRQ_EN_BIT],
    tx_fifo_event && fifo_configuration[serial_baud_pkg::FCF_TX_IRQ_EN_BIT]};

  // sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= serial_baud_pkg::RST_IRQ;
    end else if (wr_now && paddr == serial_baud_pkg::OFS_IRQ_STATUS) begin
      irq_status <= (irq_status & ~pwdata[serial_baud_pkg::IRQ_W-1:0]) | irq_set;
    end else begin
      irq_status <= irq_status | irq_set;
    end
  end

  // fifo interrupt pulses and the combined level
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_fifo_irq <= 1'b0;
      rx_fifo_irq <= 1'b0;
      irq <= 1'b0;
    end else begin
      tx_fifo_irq <= irq_set[serial_baud_pkg::IRQ_TX_FIFO];
      rx_fifo_irq <= irq_set[serial_baud_pkg::IRQ_RX_FIFO];
      // one cycle behind the status bit, to keep the output on a flip-flop
      irq <= |(irq_status & irq_mask);
    end
  end

  // read mux; unmapped offsets read zero with an error
  always_comb begin
    next_prdata = 32'h0000_0000;
    addr_ok = 1'b1;
    case (paddr)
      serial_baud_pkg::OFS_BAUD_DIVIDER: next_prdata = {24'h00_0000, baud_divider_control};
      serial_baud_pkg::OFS_BAUD_FRACTION: next_prdata = {28'h000_0000, baud_fraction_control};
      serial_baud_pkg::OFS_FIFO_CONFIG: next_prdata = {24'h00_0000, fifo_configuration};
      serial_baud_pkg::OFS_CHANNEL_ENABLE: next_prdata = {30'h0000_0000, rx_enable, tx_enable};
      serial_baud_pkg::OFS_IRQ_STATUS: next_prdata = {28'h000_0000, irq_status};
      serial_baud_pkg::OFS_IRQ_MASK: next_prdata = {28'h000_0000, irq_mask};
      serial_baud_pkg::OFS_GEN_STATUS: next_prdata = {15'h0000, tx_fifo_depth, 1'b0,
        rx_fifo_depth, 1'b0, rx_fifo_usable, frac_on, n_value};
      default: addr_ok = 1'b0;
    endcase
  end

  // apb answer: one wait state, data and error registered with pready
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (access && !pready) begin
      pready <= 1'b1;
      pslverr <= !addr_ok;
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
  end

  AST_TAP_MUX: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sel_tick |-> (tap_code == serial_baud_pkg::TAP_A && prescaler_tick_a) ||
      (tap_code == serial_baud_pkg::TAP_B && prescaler_tick_b) ||
      (tap_code == serial_baud_pkg::TAP_C && prescaler_tick_c) ||
      (tap_code == serial_baud_pkg::TAP_D && prescaler_tick_d))
    else $error("divider fed from the wrong prescaler tap");
  AST_N_DECODE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (n_value != 5'h00) && (n_value[3:0] == n_code))
    else $error("divisor code decoded wrongly");
  AST_K_ZERO_KEPT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    bad_k_write |=> $stable(baud_fraction_control) && irq_status[serial_baud_pkg::IRQ_BAD_K])
    else $error("prohibited k stored or not flagged");
  AST_USAGE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ##1 rx_fifo_usable == ($past(fifo_configuration[serial_baud_pkg::FCF_USAGE_BIT]) ?
      $past(rx_irq_fill_level) : $past(next_rx_depth)))
    else $error("receive fifo usage wrong");
  AST_TX_IRQ_GATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tx_fifo_irq |-> $past(tx_fifo_event) &&
      $past(fifo_configuration[serial_baud_pkg::FCF_TX_IRQ_EN_BIT]))
    else $error("transmit fifo interrupt while disabled");
  AST_RX_IRQ_GATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rx_fifo_event && fifo_configuration[serial_baud_pkg::FCF_RX_IRQ_EN_BIT]
    |=> rx_fifo_irq ##1 irq_status[serial_baud_pkg::IRQ_RX_FIFO])
    else $error("receive fifo interrupt lost");
  AST_NO_AUTO: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !auto_dis && !(wr_now && paddr == serial_baud_pkg::OFS_CHANNEL_ENABLE)
    |=> $stable(rx_enable) && $stable(tx_enable))
    else $error("enable changed without auto disable");
  AST_HALF_RX_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
    auto_dis && duplex_mode == serial_baud_pkg::DPX_HALF_RX && rx_done
    |=> !rx_enable)
    else $error("receive not disabled at fill target");
  AST_HALF_TX_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
    auto_dis && duplex_mode == serial_baud_pkg::DPX_HALF_TX && tx_done
    |=> !tx_enable)
    else $error("transmit not disabled after drain");
  AST_FULL_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
    auto_dis && duplex_mode == serial_baud_pkg::DPX_FULL && (rx_done || tx_done)
    |=> !rx_enable && !tx_enable ##1 irq_status[serial_baud_pkg::IRQ_AUTO_OFF])
    else $error("full duplex enables not both cleared");
  AST_DEPTH: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fifo_en && duplex_mode == serial_baud_pkg::DPX_FULL ##1 $stable(duplex_mode)
    |-> rx_fifo_depth == serial_baud_pkg::DEPTH_FULL &&
      tx_fifo_depth == serial_baud_pkg::DEPTH_FULL)
    else $error("full duplex depth wrong");
  AST_FRAC_UART: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !uart_mode |-> !frac_on)
    else $error("fractional divide outside uart mode");
  COV_AUTO_RX: cover property (@(posedge sys_clk) disable iff (!rst_n) clr_rx);
  COV_FULL_TX: cover property (@(posedge sys_clk) disable iff (!rst_n)
    duplex_mode == serial_baud_pkg::DPX_FULL && clr_tx);
  COV_IRQ: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(irq));
endmodule : serial_baud_fifo_config

// ---- verification/testbench.sv ----
// self-checking bench for the baud generator and fifo configuration block
// assumes an apb slave with one wait state and same-clock prescaler ticks
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] DIV = serial_baud_pkg::OFS_BAUD_DIVIDER;
  localparam logic [11:0] FRA = serial_baud_pkg::OFS_BAUD_FRACTION;
  localparam logic [11:0] FCF = serial_baud_pkg::OFS_FIFO_CONFIG;
  localparam logic [11:0] ENA = serial_baud_pkg::OFS_CHANNEL_ENABLE;
  localparam logic [11:0] STS = serial_baud_pkg::OFS_IRQ_STATUS;
  localparam logic [11:0] MSK = serial_baud_pkg::OFS_IRQ_MASK;
  localparam logic [11:0] GEN = serial_baud_pkg::OFS_GEN_STATUS;
  logic sys_clk = 0;
  logic rst_n = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, baud_tick, tx_enable, rx_enable, tx_fifo_irq, rx_fifo_irq, irq;
  logic [3:0] tk = 4'h0;
  logic uart_mode = 1;
  logic tx_all_empty = 0;
  logic tx_ev = 0;
  logic rx_ev = 0;
  logic [1:0] duplex_mode = 2'h0;
  logic [1:0] pl;
  logic [2:0] fill = 3'h3;
  logic [2:0] rx_valid = 3'h0;
  logic [2:0] rx_depth, tx_depth, usable;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int c, i, acc;
  int tp[4] = '{2, 3, 5, 7};
  int rxd[4] = '{0, 4, 0, 2};
  int txd[4] = '{0, 0, 4, 2};

  serial_baud_fifo_config dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prescaler_tick_a(tk[0]), .prescaler_tick_b(tk[1]),
    .prescaler_tick_c(tk[2]), .prescaler_tick_d(tk[3]), .uart_mode(uart_mode),
    .duplex_mode(duplex_mode), .rx_irq_fill_level(fill), .rx_valid_bytes(rx_valid),
    .tx_all_empty(tx_all_empty), .tx_fifo_event(tx_ev), .rx_fifo_event(rx_ev),
    .baud_tick(baud_tick), .tx_enable(tx_enable), .rx_enable(rx_enable),
    .rx_fifo_depth(rx_depth), .tx_fifo_depth(tx_depth), .rx_fifo_usable(usable),
    .tx_fifo_irq(tx_fifo_irq), .rx_fifo_irq(rx_fifo_irq), .irq(irq));

  // 200 mhz clock
  initial forever #2.5 sys_clk = ~sys_clk;

  // prescaler taps with distinct periods so a wrong tap shows in the baud period
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    for (int j = 0; j < 4; j++) tk[j] <= (cyc % tp[j] == 0);
  end

  // hang guard, far above the expected run of under a thousand cycles
  always @(posedge sys_clk) begin
    if (cyc == 20000) begin
      errors++;
      $display("[ERR] run length expected below 20000 seen 20000");
      conclude();
    end
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      errors++;
    end
  endtask : chk

  // one apb transfer; starts on an edge so psel is never assigned twice in a step
  task apb(input int w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= 1'(w);
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk) penable <= 1;
    // no cycle budget here: only the hang guard ends a wait
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  task rdc(input logic [11:0] a, input logic [31:0] e, input string n);
    apb(0, a, 32'h0000_0000);
    chk(n, e, rd);
  endtask : rdc

  // cycles from the current or next baud tick to the following one
  task per(output int n);
    int k;
    n = 0;
    for (k = 0; k < 2000 && baud_tick !== 1'b1; k++) begin
      @(posedge sys_clk);
      #1;
    end
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (baud_tick !== 1'b1 && n < 2000);
  endtask : per

  task wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : wt

  // one-cycle engine event, b 0 transmit, 1 receive; pulses captured in pl
  task ev(input int b);
    @(posedge sys_clk);
    tx_ev <= (b == 0);
    rx_ev <= (b == 1);
    @(posedge sys_clk);
    tx_ev <= 0;
    rx_ev <= 0;
    #1;
    pl = {tx_fifo_irq, rx_fifo_irq};
  endtask : ev

  task conclude;
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1;
    rdc(DIV, 32'h0000_0000, "divider reset");
    rdc(FRA, 32'h0000_0000, "fraction reset");
    rdc(FCF, 32'h0000_0000, "fifo cfg reset");
    rdc(12'h01C, 32'h0000_0000, "unmapped read");
    chk("unmapped error", 32'h0000_0001, 32'(err));
    apb(1, FCF, 32'hFFFF_FFFF);
    rdc(FCF, 32'h0000_001F, "fifo cfg bits");
    apb(1, FRA, 32'h0000_0005);
    apb(1, FRA, 32'h0000_0000);
    rdc(FRA, 32'h0000_0005, "k kept");
    rdc(STS, 32'h0000_0008, "bad k status");
    apb(1, STS, 32'h0000_000F);
    apb(1, DIV, 32'hFFFF_FFFF);
    rdc(DIV, 32'h0000_00FF, "divider bits");
    apb(1, FCF, 32'h0000_0000);
    // each tap with n of three, then code zero as sixteen
    for (i = 0; i < 4; i++) begin
      apb(1, DIV, 32'(i * 16 + 3));
      per(c);
      per(c);
      chk("tap period", 32'(3 * tp[i]), 32'(c));
    end
    apb(1, DIV, 32'h0000_0000);
    per(c);
    per(c);
    chk("n sixteen", 32'd32, 32'(c));
    rdc(GEN, 32'h0000_0010, "n value");
    // n 4, k 12: sixteen periods hold 64 + 4 ticks of 2 cycles
    apb(1, FRA, 32'h0000_000C);
    apb(1, DIV, 32'h0000_0044);
    per(c);
    acc = 0;
    for (i = 0; i < 16; i++) begin
      per(c);
      acc += c;
    end
    chk("fraction sum", 32'd136, 32'(acc));
    rdc(GEN, 32'h0000_0024, "frac active");
    @(posedge sys_clk) uart_mode <= 0;
    per(c);
    per(c);
    chk("frac off", 32'd8, 32'(c));
    apb(1, FCF, 32'h0000_0001);
    for (i = 0; i < 4; i++) begin
      @(posedge sys_clk) duplex_mode <= 2'(i);
      wt(3);
      chk("rx depth", 32'(rxd[i]), 32'(rx_depth));
      chk("tx depth", 32'(txd[i]), 32'(tx_depth));
      chk("usable max", 32'(rxd[i]), 32'(usable));
    end
    @(posedge sys_clk) duplex_mode <= 2'h1;
    apb(1, FCF, 32'h0000_0013);
    wt(2);
    chk("usable fill", 32'd3, 32'(usable));
    apb(1, ENA, 32'h0000_0002);
    @(posedge sys_clk) rx_valid <= 3'h2;
    wt(4);
    chk("rx below fill", 32'd1, 32'(rx_enable));
    @(posedge sys_clk) rx_valid <= 3'h3;
    wt(3);
    chk("rx auto off", 32'd0, 32'(rx_enable));
    @(posedge sys_clk) duplex_mode <= 2'h3;
    rx_valid <= 3'h0;
    apb(1, FCF, 32'h0000_0003);
    apb(1, ENA, 32'h0000_0003);
    @(posedge sys_clk) rx_valid <= 3'h2;
    wt(3);
    chk("full both off", 32'd0, 32'({tx_enable, rx_enable}));
    @(posedge sys_clk) duplex_mode <= 2'h2;
    rx_valid <= 3'h0;
    apb(1, FCF, 32'h0000_0001);
    apb(1, ENA, 32'h0000_0001);
    @(posedge sys_clk) tx_all_empty <= 1;
    wt(4);
    chk("no auto", 32'd1, 32'(tx_enable));
    @(posedge sys_clk) tx_all_empty <= 0;
    apb(1, FCF, 32'h0000_0003);
    @(posedge sys_clk) tx_all_empty <= 1;
    wt(3);
    chk("tx auto off", 32'd0, 32'(tx_enable));
    rdc(STS, 32'h0000_0004, "auto status");
    apb(1, STS, 32'h0000_000F);
    apb(1, MSK, 32'h0000_0003);
    // gated then enabled event for each direction, then mask and clear
    for (i = 0; i < 2; i++) begin
      apb(1, FCF, 32'h0000_0001);
      ev(i);
      chk("gated pulse", 32'd0, 32'(pl));
      rdc(STS, 32'h0000_0000, "gated status");
      apb(1, FCF, (i == 0) ? 32'h0000_0009 : 32'h0000_0005);
      ev(i);
      chk("fifo pulse", 32'(2 >> i), 32'(pl));
      wt(2);
      chk("irq on", 32'd1, 32'(irq));
      rdc(STS, 32'(1 << i), "event status");
      apb(1, MSK, 32'h0000_0000);
      wt(2);
      chk("irq masked", 32'd0, 32'(irq));
      apb(1, MSK, 32'h0000_0003);
      apb(1, STS, 32'(1 << i));
      wt(2);
      chk("irq cleared", 32'd0, 32'(irq));
    end
    conclude();
  end
endmodule : testbench
